// ### dv/ucg_ctrl_model.sv
// Behavioural model of the USB controllers that sit behind the clock gating block.
`timescale 1ns/1ns
`default_nettype none

module ucg_ctrl_model (
    input  wire logic                 clk_sys_in,
    input  wire ucg_pkg::ucg_ctl_in_t pins_cmd_in,
    input  wire logic [3:0]           ctrl_sel_in,
    input  wire logic                 ctrl_write_in,
    input  wire logic [7:0]           ctrl_addr_in,
    input  wire logic [31:0]          ctrl_wdata_in,
    output ucg_pkg::ucg_ctl_in_t      ctl_status_out,
    output logic [31:0]               ctrl_rdata_out,
    output logic [31:0]               last_wdata_out
);
    import ucg_pkg::*;

    logic [31:0] idle_pat_r = 32'h0f0f_0f0f;

    //////////////////////////////////////////////////////////////////////////
    // Suspend, activity and attach states move only just after an edge, like real flops.
    always @(posedge clk_sys_in) begin
        ctl_status_out <= pins_cmd_in;
        idle_pat_r     <= ~idle_pat_r;
        if (|ctrl_sel_in && ctrl_write_in) begin
            last_wdata_out <= ctrl_wdata_in;
        end
    end

    // An unselected read bus toggles every cycle, so a stale word can never pass for an answer.
    assign ctrl_rdata_out = (|ctrl_sel_in) ? {16'h5a5a, 4'h0, ctrl_sel_in, ctrl_addr_in} : idle_pat_r;
endmodule : ucg_ctrl_model

`default_nettype wire

// ### dv/usb_clock_gating_and_wake_tb_top.sv
// Self-checking testbench for the USB clock gating and wake block.
`timescale 1ns/1ns
`default_nettype none

module usb_clock_gating_and_wake_tb_top;
    import ucg_pkg::*;

    localparam int unsigned HOLD = 20;
    localparam logic [7:0] PV [8] = '{8'h14, 8'h15, 8'h17, 8'h12, 8'h00, 8'h30, 8'h50, 8'h10};
    localparam logic [4:0] EV [8] = '{5'h01, 5'h00, 5'h01, 5'h00, 5'h02, 5'h02, 5'h02, 5'h00};

    logic        clk_sys_in;
    logic        reset_in;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic [1:0]  avs_response;
    logic        avs_waitrequest;
    ucg_ctl_in_t ctl_status;
    ucg_ctl_in_t pins;
    ucg_sw_t     clk_en;
    logic [3:0]  ctrl_sel;
    logic        ctrl_write;
    logic [7:0]  ctrl_addr;
    logic [31:0] ctrl_wdata;
    logic [31:0] ctrl_rdata;
    logic [31:0] last_wdata;
    logic        wake;
    logic        irq;
    logic [31:0] rd;
    logic [1:0]  rsp;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cyc_cnt = 0;

    ucg_top #(.DMA_HOLD_CYC(HOLD)) ucg_top_inst (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata), .avs_response_out(avs_response),
        .avs_waitrequest_out(avs_waitrequest), .ctl_status_in(ctl_status), .clk_en_out(clk_en),
        .ctrl_sel_out(ctrl_sel), .ctrl_write_out(ctrl_write), .ctrl_addr_out(ctrl_addr),
        .ctrl_wdata_out(ctrl_wdata), .ctrl_rdata_in(ctrl_rdata), .wake_out(wake), .irq_out(irq));

    ucg_ctrl_model ucg_ctrl_model_inst (
        .clk_sys_in(clk_sys_in), .pins_cmd_in(pins), .ctrl_sel_in(ctrl_sel),
        .ctrl_write_in(ctrl_write), .ctrl_addr_in(ctrl_addr), .ctrl_wdata_in(ctrl_wdata),
        .ctl_status_out(ctl_status), .ctrl_rdata_out(ctrl_rdata), .last_wdata_out(last_wdata));

    //////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : tick

    // One Avalon transfer; the request stands until waitrequest is seen low at an edge.
    task automatic bus(input logic [7:0] off, input logic w, input logic [31:0] d, input logic [3:0] win = WIN_OWN);
        @(posedge clk_sys_in);
        avs_address   <= {win, off};
        avs_read      <= ~w;
        avs_write     <= w;
        avs_writedata <= d;
        do @(posedge clk_sys_in); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic set_pins(input logic [7:0] v);
        @(posedge clk_sys_in);
        pins <= v;
        tick(8);
    endtask : set_pins

    //////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    always @(posedge clk_sys_in) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        int k;
        reset_in = 1'b1;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        pins = 8'h10;
        tick(2);
        reset_in <= 1'b0;
        bus(OFF_CLK_CTRL, 0, 0); check("clk_ctrl_reset", rd, 32'h0000_0000);
        bus(OFF_PWR, 0, 0); check("pwr_reset", rd, 32'h0000_0000);
        bus(8'h20, 0, 0, WIN_DEV); check("gated_rsp", rsp, RESP_SLVERR);
        check("gated_data", rd, 32'h0000_0000);
        bus(8'h40, 0, 0); check("unmapped_rsp", rsp, RESP_DECERR);
        bus(8'h00, 0, 0, 4'h5); check("window_rsp", rsp, RESP_DECERR);
        bus(OFF_IRQ_STAT, 0, 0); check("buserr_irq", rd & 32'h0000_0104, 32'h0000_0004);
        bus(OFF_PWR, 1, 32'h0000_0001);
        for (int w = 0; w < 5; w++) begin
            bus(OFF_CLK_CTRL, 1, 32'(1 << w));
            k = 0;
            do begin
                bus(OFF_CLK_STAT, 0, 0);
                k++;
            end while (rd[w] !== 1'b1 && k < 20);
            check("clk_stat", rd, 32'(1 << w));
            check("clk_en", clk_en, 32'(1 << w));
            tick(20);
            check("clk_held", clk_en, 32'(1 << w));
            if (w < 4) begin
                bus(8'h20, 1, 32'hc0de_0000 + w, 4'(w + 1));
                check("fwd_wr", last_wdata, 32'hc0de_0000 + w);
                bus(8'h20, 0, 0, 4'(w + 1)); check("open_rsp", rsp, RESP_OKAY);
                check("open_data", rd, {16'h5a5a, 4'h0, 4'(1 << w), 8'h20});
            end
        end
        bus(OFF_CLK_CTRL, 1, 32'h0000_001f);
        bus(OFF_PWR, 1, 32'h0000_0000);
        tick(3);
        check("power_off", clk_en, 32'h0000_0000);
        bus(OFF_CLK_STAT, 0, 0); check("power_off_stat", rd, 32'h0000_0000);
        bus(OFF_PWR, 1, 32'h0000_0001);
        bus(OFF_CLK_CTRL, 1, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            set_pins(PV[i]);
            check("req_clock", clk_en, EV[i]);
        end
        foreach (PV[j]) begin
            if (j < 2) begin
                @(posedge clk_sys_in);
                pins <= (j == 0) ? 8'h18 : 8'h90;
                tick(2);
                pins <= 8'h10;
                tick(10);
                check("dma_on", clk_en, 32'h0000_0010);
                tick(HOLD / 2 + 4);
                check("dma_hold", clk_en, 32'h0000_0010);
                tick(2);
                check("dma_drop", clk_en, 32'h0000_0000);
            end
        end
        bus(OFF_IRQ_CLR, 1, 32'h0000_0007);
        bus(OFF_IRQ_STAT, 0, 0); check("irq_clear", rd, 32'h0000_0000);
        bus(OFF_PWR, 1, 32'h0000_0003);
        bus(OFF_IRQ_EN, 1, 32'h0000_0001);
        tick(3);
        check("wake_idle", {wake, irq}, 32'h0000_0000);
        set_pins(8'h14);
        check("wake_up", {wake, irq}, 32'h0000_0003);
        bus(OFF_IRQ_STAT, 0, 0); check("need_stat", rd, 32'h0000_0101);
        bus(OFF_IRQ_EN, 1, 32'h0000_0000); tick(1);
        check("irq_masked", irq, 32'h0000_0000);
        bus(OFF_IRQ_EN, 1, 32'h0000_0003);
        bus(OFF_IRQ_CLR, 1, 32'h0000_0001); tick(1);
        check("irq_cleared", irq, 32'h0000_0000);
        set_pins(8'h10);
        bus(OFF_IRQ_STAT, 0, 0); check("need_fell", rd, 32'h0000_0002);
        check("wake_gone", {wake, irq}, 32'h0000_0001);
        bus(OFF_CLK_CTRL, 1, 32'h0000_0004); tick(3);
        check("wake_by_enable", wake, 32'h0000_0001);
        bus(OFF_CLK_CTRL, 1, 32'h0000_0000); tick(3);
        check("wake_released", wake, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : usb_clock_gating_and_wake_tb_top

`default_nettype wire

// ### hw/ucg_dma_hold.sv
// Hold timer that stretches DMA activity into a clock request.
`timescale 1ns/1ns
`default_nettype none

module ucg_dma_hold #(
    parameter int unsigned HOLD_CYC = ucg_pkg::DMA_HOLD_CYCLES
) (
    input  wire logic clk_sys_in,
    input  wire logic reset_in,
    input  wire logic access_in,
    output logic      need_out
);
    import ucg_pkg::*;

    localparam logic [HOLD_W-1:0] RELOAD = HOLD_W'(HOLD_CYC - 1);

    logic [HOLD_W-1:0] cnt_r;
    logic [HOLD_W-1:0] cnt_nxt;

    // The request stands while accesses come and for the hold time after the last.
    assign cnt_nxt  = access_in ? RELOAD : (cnt_r != '0) ? cnt_r - HOLD_W'(1) : cnt_r;
    assign need_out = access_in | (cnt_r != '0);

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : ucg_dma_hold

`default_nettype wire

// ### hw/ucg_pkg.sv
// Package of constants and carrier types for the USB clock gating and wake block.
package ucg_pkg;

    //////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_PERIOD_NS   = 100;
    localparam int DMA_HOLD_US     = 2000;
    // A least hold time, so the division rounds up.
    localparam int DMA_HOLD_CYCLES = (DMA_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_W          = 16;

    //////////////////////////////////////////////////////////////////////////
    // Bus geometry and answers.
    localparam int       AW          = 12;
    localparam int       DW          = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    //////////////////////////////////////////////////////////////////////////
    // Address windows, selected by address bits 11:8.
    localparam logic [3:0] WIN_OWN  = 4'h0;
    localparam logic [3:0] WIN_DEV  = 4'h1;
    localparam logic [3:0] WIN_HOST = 4'h2;
    localparam logic [3:0] WIN_OTG  = 4'h3;
    localparam logic [3:0] WIN_I2C  = 4'h4;

    //////////////////////////////////////////////////////////////////////////
    // Register byte offsets inside the own window.
    localparam logic [7:0] OFF_CLK_CTRL = 8'h00;
    localparam logic [7:0] OFF_CLK_STAT = 8'h04;
    localparam logic [7:0] OFF_PWR      = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h10;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h14;
    localparam logic [7:0] OFF_REQ_STAT = 8'h18;

    //////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int         PWR_ON_BIT   = 0;
    localparam int         PWR_WAKE_BIT = 1;
    localparam int         IRQ_NEED_BIT = 8;
    localparam logic [4:0] CLK_CTRL_RST = 5'h00;
    localparam logic [1:0] PWR_RST      = 2'h0;
    localparam logic [2:0] IRQ_EN_RST   = 3'h0;

    //////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef struct packed {
        logic ahb;
        logic i2c;
        logic otg;
        logic host;
        logic dev;
    } ucg_sw_t;

    typedef struct packed {
        logic host_dma;
        logic host_disc;
        logic host_resume;
        logic host_susp;
        logic dev_dma;
        logic dev_attach;
        logic dev_act;
        logic dev_susp;
    } ucg_ctl_in_t;

    typedef struct packed {
        logic host_dma;
        logic host;
        logic dev_dma;
        logic dev;
    } ucg_req_t;

    typedef struct packed {
        logic buserr;
        logic idle;
        logic wake;
    } ucg_irq_t;

endpackage : ucg_pkg

// ### hw/ucg_top.sv
// USB subsystem clock gating, clock request and wake logic with its register slave.
// Notes on behaviour
// - Each gated switch turns its clock on and raises clock-on when enabled.
// - Clock-on indicators of all switches are readable in the clock status register.
// - Clearing a controller enable bit turns that controller clock off; device and host clocks stay on while their request stands.
// - Clearing the subsystem power bit gates off every subsystem clock.
// - A software enabled clock stays on until software clears the enable; the code also gates it off when the subsystem power bit is cleared.
// - Access to a controller whose clock is off answers with a bus error.
// - Device request turns on its clock; device DMA request turns on the master clock.
// - Device request stands while not suspended, or suspended with bus activity.
// - Device request drops when the attach state bit is cleared.
// - Device DMA request holds for 2 ms after the last DMA access.
// - Host request turns on its clock; host DMA request turns on the master clock.
// - Host request stands unless suspended without resume or disconnect.
// - Host DMA request holds for 2 ms after the last DMA access.
// - With wake enabled, the combined request wakes the chip from power-down.
// - The combined request is readable in the interrupt status register.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ns
`default_nettype none

module ucg_top #(
    parameter int unsigned DMA_HOLD_CYC = ucg_pkg::DMA_HOLD_CYCLES
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  reset_in,
    input  wire logic [ucg_pkg::AW-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [ucg_pkg::DW-1:0] avs_writedata_in,
    output logic [ucg_pkg::DW-1:0]     avs_readdata_out,
    output logic [1:0]                 avs_response_out,
    output logic                       avs_waitrequest_out,
    input  wire ucg_pkg::ucg_ctl_in_t  ctl_status_in,
    output ucg_pkg::ucg_sw_t           clk_en_out,
    output logic [3:0]                 ctrl_sel_out,
    output logic                       ctrl_write_out,
    output logic [7:0]                 ctrl_addr_out,
    output logic [ucg_pkg::DW-1:0]     ctrl_wdata_out,
    input  wire logic [ucg_pkg::DW-1:0] ctrl_rdata_in,
    output logic                       wake_out,
    output logic                       irq_out
);
    import ucg_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Window decode, used for the forward strobes and the error check.
    function automatic logic [3:0] win_onehot(input logic [3:0] win);
        win_onehot = {win == WIN_I2C, win == WIN_OTG, win == WIN_HOST, win == WIN_DEV};
    endfunction : win_onehot

    //////////////////////////////////////////////////////////////////////////
    // Controller status comes from the 48 MHz side: three flops, then agreement.
    ucg_ctl_in_t sync1_r;
    ucg_ctl_in_t sync2_r;
    ucg_ctl_in_t sync3_r;
    ucg_ctl_in_t ctl_r;
    ucg_ctl_in_t ctl_nxt;

    // A level that stands for a single sampled cycle never reaches ctl_r, so a
    // glitch on a controller status line cannot switch a clock on its own.
    genvar gi;
    generate
        for (gi = 0; gi < $bits(ucg_ctl_in_t); gi++) begin : g_agree
            assign ctl_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : ctl_r[gi];
        end
    endgenerate

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            ctl_r   <= '0;
        end else begin
            sync1_r <= ctl_status_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            ctl_r   <= ctl_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Clock requests from the controllers.
    ucg_req_t req;

    assign req.dev  = ctl_r.dev_attach & (~ctl_r.dev_susp | ctl_r.dev_act);
    assign req.host = ~ctl_r.host_susp | ctl_r.host_resume | ctl_r.host_disc;

    // The hold keeps the master clock up across short DMA gaps, trading power for latency.
    ucg_dma_hold #(
        .HOLD_CYC (DMA_HOLD_CYC)
    ) u_dev_hold (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .access_in  (ctl_r.dev_dma),
        .need_out   (req.dev_dma)
    );

    ucg_dma_hold #(
        .HOLD_CYC (DMA_HOLD_CYC)
    ) u_host_hold (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .access_in  (ctl_r.host_dma),
        .need_out   (req.host_dma)
    );

    //////////////////////////////////////////////////////////////////////////
    // Software registers.
    ucg_sw_t    ctrl_en_r;
    logic [1:0] pwr_r;
    ucg_irq_t   irq_en_r;
    ucg_irq_t   irq_st_r;
    ucg_sw_t    on_r;
    logic       need_d_r;
    logic       ack_r;

    logic power_on;
    logic wake_en;
    assign power_on = pwr_r[PWR_ON_BIT];
    assign wake_en  = pwr_r[PWR_WAKE_BIT];

    //////////////////////////////////////////////////////////////////////////
    // Switch enables and clock-on indicators.
    ucg_sw_t sw_en;

    assign sw_en.dev  = power_on & (ctrl_en_r.dev | req.dev);
    assign sw_en.host = power_on & (ctrl_en_r.host | req.host);
    assign sw_en.otg  = power_on & ctrl_en_r.otg;
    assign sw_en.i2c  = power_on & ctrl_en_r.i2c;
    assign sw_en.ahb  = power_on & (ctrl_en_r.ahb | req.dev_dma | req.host_dma);

    // The gate and its clock-on report come from one flop, so they never disagree.
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            on_r <= '0;
        end else begin
            on_r <= sw_en;
        end
    end

    assign clk_en_out = on_r;

    //////////////////////////////////////////////////////////////////////////
    // Combined request and wake.
    logic need_all;
    assign need_all = (|req) | (|ctrl_en_r);

    logic wake_r;
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            wake_r   <= 1'b0;
            need_d_r <= 1'b0;
        end else begin
            wake_r   <= wake_en & need_all;
            need_d_r <= need_all;
        end
    end

    assign wake_out = wake_r;

    //////////////////////////////////////////////////////////////////////////
    // Bus decode. Every access waits one cycle, then is answered.
    logic       req_any;
    logic       fire;
    logic       wr_fire;
    logic [3:0] win;
    logic [7:0] off;
    logic [3:0] win_hit;
    logic       win_on;
    logic       is_own;
    logic       own_known;
    logic       gated_err;

    assign req_any  = avs_read_in | avs_write_in;
    assign fire     = req_any & ~ack_r;
    assign wr_fire  = avs_write_in & ack_r;
    assign win      = avs_address_in[11:8];
    assign off      = avs_address_in[7:0];
    assign win_hit  = win_onehot(win);
    assign win_on   = |(win_hit & {on_r.i2c, on_r.otg, on_r.host, on_r.dev});
    assign is_own   = (win == WIN_OWN);
    assign own_known = (off == OFF_CLK_CTRL) | (off == OFF_CLK_STAT) | (off == OFF_PWR) |
                       (off == OFF_IRQ_STAT) | (off == OFF_IRQ_CLR) | (off == OFF_IRQ_EN) |
                       (off == OFF_REQ_STAT);
    assign gated_err = (|win_hit) & ~win_on;

    assign avs_waitrequest_out = req_any & ~ack_r;

    // A controller must return its read word in the strobe cycle; it cannot stretch
    // the access, which keeps every bus answer at exactly one wait state.
    // Forwarded controller access, only while that controller's clock runs.
    assign ctrl_sel_out   = fire & ~gated_err ? win_hit : 4'h0;
    assign ctrl_write_out = avs_write_in;
    assign ctrl_addr_out  = off;
    assign ctrl_wdata_out = avs_writedata_in;

    logic [DW-1:0] own_rd;
    assign own_rd = (off == OFF_CLK_CTRL) ? DW'(ctrl_en_r) :
                    (off == OFF_CLK_STAT) ? DW'(on_r) :
                    (off == OFF_PWR)      ? DW'(pwr_r) :
                    (off == OFF_IRQ_STAT) ? (DW'(irq_st_r) | (DW'(need_all) << IRQ_NEED_BIT)) :
                    (off == OFF_IRQ_EN)   ? DW'(irq_en_r) :
                    (off == OFF_REQ_STAT) ? DW'(req) : 32'h0000_0000;

    logic [1:0]    resp_nxt;
    logic [DW-1:0] rdata_nxt;
    logic [1:0]    resp_r;
    logic [DW-1:0] rdata_r;

    assign resp_nxt  = is_own ? (own_known ? RESP_OKAY : RESP_DECERR) :
                       (|win_hit) ? (gated_err ? RESP_SLVERR : RESP_OKAY) : RESP_DECERR;
    assign rdata_nxt = ~avs_read_in | (resp_nxt != RESP_OKAY) ? 32'h0000_0000 :
                       is_own ? own_rd : ctrl_rdata_in;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ack_r   <= 1'b0;
            resp_r  <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= fire;
            resp_r  <= fire ? resp_nxt : resp_r;
            rdata_r <= fire ? rdata_nxt : rdata_r;
        end
    end

    assign avs_response_out = resp_r;
    assign avs_readdata_out = rdata_r;

    //////////////////////////////////////////////////////////////////////////
    // Register writes take effect at the edge where waitrequest is seen low.
    logic wr_own;
    assign wr_own = wr_fire & is_own;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_en_r <= CLK_CTRL_RST;
            pwr_r     <= PWR_RST;
            irq_en_r  <= IRQ_EN_RST;
        end else begin
            if (wr_own && off == OFF_CLK_CTRL) begin
                ctrl_en_r <= avs_writedata_in[4:0];
            end
            if (wr_own && off == OFF_PWR) begin
                pwr_r <= avs_writedata_in[1:0];
            end
            if (wr_own && off == OFF_IRQ_EN) begin
                irq_en_r <= avs_writedata_in[2:0];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event in the clearing cycle survives the clear.
    ucg_irq_t ev;
    ucg_irq_t clr;
    assign ev.wake   = wake_en & need_all & ~need_d_r;
    assign ev.idle   = need_d_r & ~need_all;
    assign ev.buserr = fire & gated_err;
    assign clr       = (wr_own && off == OFF_IRQ_CLR) ? avs_writedata_in[2:0] : 3'h0;

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            irq_st_r <= '0;
        end else begin
            irq_st_r <= (irq_st_r & ~clr) | ev;
        end
    end

    assign irq_out = |(irq_st_r & irq_en_r);

    //////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    chk_switch_on: assert property (sw_en.otg |=> clk_en_out.otg)
        else $error("otg switch enable did not turn its clock on");
    chk_status_read: assert property ((fire && avs_read_in && is_own && off == OFF_CLK_STAT)
        |=> avs_readdata_out[4:0] == $past(on_r))
        else $error("clock status read does not show the clock-on bits");
    chk_clear_off: assert property (!ctrl_en_r.i2c |=> !clk_en_out.i2c)
        else $error("i2c clock still on after its enable was cleared");
    chk_power_gate: assert property (!power_on |=> clk_en_out == '0)
        else $error("clock running with subsystem power bit cleared");
    chk_enable_keep: assert property ((power_on && ctrl_en_r.dev) [*2] |-> clk_en_out.dev)
        else $error("enabled device clock dropped");
    chk_gated_error: assert property ((fire && gated_err)
        |=> avs_response_out == RESP_SLVERR && !avs_waitrequest_out && ctrl_sel_out == 4'h0)
        else $error("access to gated controller was not answered with an error");
    chk_dev_request: assert property ((power_on && req.dev) |=> clk_en_out.dev)
        else $error("device request did not turn on the device clock");
    chk_dev_detach: assert property (!ctl_r.dev_attach |-> !req.dev)
        else $error("device request stands after detach");
    chk_dma_hold: assert property ($fell(ctl_r.dev_dma) |-> req.dev_dma [*8])
        else $error("device DMA request dropped before the hold time");
    chk_host_request: assert property ((power_on && ctl_r.host_susp && !ctl_r.host_resume
        && !ctl_r.host_disc && !ctrl_en_r.host) |=> !clk_en_out.host)
        else $error("suspended host clock still running");
    chk_host_dma: assert property ((power_on && ctl_r.host_dma) |=> clk_en_out.ahb ##1 req.host_dma)
        else $error("host DMA did not raise the master clock");
    chk_wake_out: assert property ((wake_en && need_all) |=> wake_out)
        else $error("combined request with wake enabled did not wake");
    chk_need_read: assert property ((fire && avs_read_in && is_own && off == OFF_IRQ_STAT)
        |=> avs_readdata_out[IRQ_NEED_BIT] == $past(need_all))
        else $error("combined request missing from interrupt status");
    chk_need_or: assert property ((req == '0 && ctrl_en_r == '0) |-> !need_all)
        else $error("combined request high with no source");

    // Each request path is watched at the switch output one edge later, so a broken
    // decode shows up on the clock that software and the controllers would see.
    chk_host_idle: assert property ((power_on && !ctl_r.host_susp)
        |=> clk_en_out.host)
        else $error("host clock off while the host is not suspended");
    chk_host_resume: assert property ((power_on && (ctl_r.host_resume || ctl_r.host_disc))
        |=> clk_en_out.host)
        else $error("host clock off during resume or disconnect");
    chk_dev_activity: assert property ((power_on && ctl_r.dev_attach && ctl_r.dev_act)
        |=> clk_en_out.dev)
        else $error("device clock off with bus activity while attached");
    chk_dev_dma_on: assert property ((power_on && ctl_r.dev_dma)
        |=> clk_en_out.ahb)
        else $error("device DMA did not turn on the master clock");
    chk_ahb_release: assert property ((!ctrl_en_r.ahb && !req.dev_dma && !req.host_dma)
        |=> !clk_en_out.ahb)
        else $error("master clock still on with no DMA request and no enable");
    chk_wake_quiet: assert property ((!wake_en || !need_all)
        |=> !wake_out)
        else $error("wake raised without enable or request");
    chk_gated_quiet: assert property ((req_any && gated_err)
        |-> ctrl_sel_out == 4'h0)
        else $error("access to a gated controller was forwarded");
    chk_enable_clear: assert property ((wr_own && off == OFF_CLK_CTRL && !avs_writedata_in[2])
        |=> !ctrl_en_r.otg)
        else $error("otg enable bit not cleared by software write");

    cov_wake: cover property (wake_en && $rose(need_all));
    cov_buserr: cover property (fire && gated_err);
    cov_dma_drop: cover property ($fell(req.dev_dma));
    cov_irq: cover property ($rose(irq_out));
    cov_forward: cover property (|ctrl_sel_out && ctrl_write_out);

endmodule : ucg_top

`default_nettype wire
